// ==== hdl/slpc_regs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef SLPC_REGS_SVH
`define SLPC_REGS_SVH
`define SLPC_A_CTRL 8'h00
`define SLPC_A_STAT 8'h04
`define SLPC_A_ISR 8'h08
`define SLPC_A_IMR 8'h0c
`define SLPC_A_CCC 8'h10
`define SLPC_A_CCNT 8'h14
`define SLPC_C_PMEN 0
`define SLPC_C_SLREQ 1
`define SLPC_C_PAREQ 2
`define SLPC_C_SRST 3
`define SLPC_C_SUSP 4
`define SLPC_C_WAKE 5
`define SLPC_I_CCC 0
`define SLPC_I_DPS 1
`define SLPC_I_PMDONE 2
`define SLPC_I_PDDONE 3
`define SLPC_I_PDREF 4
`define SLPC_NIRQ 5
`define SLPC_CCC_EN 0
`define SLPC_CCC_THR_LSB 8
`define SLPC_ST_PM_LSB 4
`define SLPC_ST_PD_LSB 8
`define SLPC_IMR_RST 5'h00
`define SLPC_THR_RST 8'h00
`define SLPC_CLK_NS 50
`define SLPC_PD_STEP_NS 1000
`define SLPC_PD_STEP_CYC ((`SLPC_PD_STEP_NS + `SLPC_CLK_NS - 1) / `SLPC_CLK_NS)
`define SLPC_PM_TMO_NS 10000
`define SLPC_PM_TMO_CYC (`SLPC_PM_TMO_NS / `SLPC_CLK_NS)
`endif

// ==== hdl/slpc_pkg.sv ====
// Types and helpers shared by the link power control block
`include "slpc_regs.svh"
package slpc_pkg;
	typedef enum logic [2:0] {
		PR_SYNC, PR_XRDY, PR_RRDY, PR_PMACK, PR_PMNAK, PR_PMREQ_P, PR_PMREQ_S
	} slpc_prim_e;
	typedef enum logic [1:0] {PM_NONE, PM_PARTIAL, PM_SLUMBER} slpc_pm_e;
	typedef enum logic [2:0] {L_IDLE, L_TX, L_RX, L_PMREQ, L_PM} slpc_link_e;
	typedef enum logic [2:0] {
		PD_ON, PD_RX, PD_TX, PD_MPLL, PD_GATE, PD_OFF
	} slpc_pd_e;
	// Primitives seen on the receive side, sampled as levels every cycle
	typedef struct packed {
		logic xrdy;
		logic pmreq_p;
		logic pmreq_s;
		logic pmack;
		logic pmnak;
		logic wake;
		logic dvalid;
	} slpc_rx_s;
	typedef struct packed {
		logic rx_pll;
		logic rx;
		logic tx;
		logic mpll;
		logic main_pll_clock_gate;
		logic refclk_stop_ok;
	} slpc_phypd_s;
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
		logic en;
	} slpc_wr_s;

	function automatic logic slpc_mapped(input logic [7:0] a);
		case (a)
			`SLPC_A_CTRL, `SLPC_A_STAT, `SLPC_A_ISR, `SLPC_A_IMR,
			`SLPC_A_CCC, `SLPC_A_CCNT: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : slpc_mapped

	function automatic logic [31:0] slpc_wmask(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : slpc_wmask
endpackage : slpc_pkg

// ==== hdl/slpc_axil.sv ====
// AXI4-Lite slave front end: one write and one read in flight
`timescale 1ns/1ps
`default_nettype none
module slpc_axil (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Write channels
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// Read channels
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Register side
	output slpc_pkg::slpc_wr_s wr,
	output logic [7:0] rd_addr,
	input wire logic [31:0] rd_data
);
	typedef struct packed {
		logic aw_full;
		logic w_full;
		slpc_pkg::slpc_wr_s wr;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} slpc_axil_s;
	slpc_axil_s s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.wr.en = 1'b0;
		if (awvalid && s_q.awready) begin
			s_d.aw_full = 1'b1;
			s_d.wr.addr = awaddr;
		end
		if (wvalid && s_q.wready) begin
			s_d.w_full = 1'b1;
			s_d.wr.data = wdata;
			s_d.wr.strb = wstrb;
		end
		if (s_q.bvalid && bready) begin
			s_d.bvalid = 1'b0;
		end
		if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
			s_d.wr.en = 1'b1;
			s_d.aw_full = 1'b0;
			s_d.w_full = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = slpc_pkg::slpc_mapped(s_q.wr.addr) ? 2'h0 : 2'h2;
		end
		// Hold off new writes until the response has gone
		s_d.awready = !s_d.aw_full && !s_d.bvalid;
		s_d.wready = !s_d.w_full && !s_d.bvalid;
		if (arvalid && s_q.arready) begin
			s_d.arready = 1'b0;
			s_d.rvalid = 1'b1;
			s_d.rdata = rd_data;
			s_d.rresp = slpc_pkg::slpc_mapped(araddr) ? 2'h0 : 2'h2;
		end
		if (s_q.rvalid && rready) begin
			s_d.rvalid = 1'b0;
			s_d.arready = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
			s_q.awready <= 1'b1;
			s_q.wready <= 1'b1;
			s_q.arready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign awready = s_q.awready;
	assign wready = s_q.wready;
	assign bvalid = s_q.bvalid;
	assign bresp = s_q.bresp;
	assign arready = s_q.arready;
	assign rvalid = s_q.rvalid;
	assign rdata = s_q.rdata;
	assign rresp = s_q.rresp;
	assign wr = s_q.wr;
	assign rd_addr = araddr;
endmodule : slpc_axil
`default_nettype wire

// ==== hdl/slpc_phy_pd.sv ====
// Ordered PHY power-down sequencer ahead of reference clock stop
`timescale 1ns/1ps
`default_nettype none
`include "slpc_regs.svh"
module slpc_phy_pd (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Requests
	input wire logic start,
	input wire logic release_req,
	input wire logic in_slumber,
	// Controls and events
	output slpc_pkg::slpc_phypd_s pd,
	output slpc_pkg::slpc_pd_e step,
	output logic done,
	output logic refused
);
	localparam int STEP = `SLPC_PD_STEP_CYC;
	typedef struct packed {
		slpc_pkg::slpc_pd_e st;
		logic [7:0] cnt;
		slpc_pkg::slpc_phypd_s pd;
		logic done;
		logic refused;
	} slpc_pdq_s;
	slpc_pdq_s s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.refused = 1'b0;
		if (release_req) begin
			s_d.st = slpc_pkg::PD_ON;
			s_d.cnt = '0;
		end else begin
			case (s_q.st)
				slpc_pkg::PD_ON: begin
					if (start && in_slumber) begin
						s_d.st = slpc_pkg::PD_RX;
						s_d.cnt = '0;
					end else if (start) begin
						s_d.refused = 1'b1;
					end
				end
				slpc_pkg::PD_OFF: begin
				end
				default: begin
					if (s_q.cnt == 8'(STEP - 1)) begin
						s_d.cnt = '0;
						s_d.st = slpc_pkg::slpc_pd_e'(s_q.st + 3'h1);
						s_d.done = (s_q.st == slpc_pkg::PD_GATE);
					end else begin
						s_d.cnt = s_q.cnt + 8'h01;
					end
				end
			endcase
		end
		// Each stage keeps every earlier stage down
		s_d.pd.rx_pll = (s_d.st >= slpc_pkg::PD_RX);
		s_d.pd.rx = (s_d.st >= slpc_pkg::PD_RX);
		s_d.pd.tx = (s_d.st >= slpc_pkg::PD_TX);
		s_d.pd.mpll = (s_d.st >= slpc_pkg::PD_MPLL);
		s_d.pd.main_pll_clock_gate = (s_d.st >= slpc_pkg::PD_GATE);
		s_d.pd.refclk_stop_ok = (s_d.st == slpc_pkg::PD_OFF);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pd = s_q.pd;
	assign step = s_q.st;
	assign done = s_q.done;
	assign refused = s_q.refused;

	property p_tx_after_rx;
		@(posedge clk) disable iff (!reset_n)
		$rose(pd.tx) |-> pd.rx && pd.rx_pll && $past(pd.rx, STEP);
	endproperty
	a_tx_after_rx: assert property (p_tx_after_rx) else $error("tx down early");
	property p_mpll_after_tx;
		@(posedge clk) disable iff (!reset_n)
		$rose(pd.mpll) |-> pd.tx && $past(pd.tx, STEP);
	endproperty
	a_mpll_after_tx: assert property (p_mpll_after_tx) else $error("mpll early");
	property p_gate_after_mpll;
		@(posedge clk) disable iff (!reset_n)
		$rose(pd.main_pll_clock_gate) |-> pd.mpll && $past(pd.mpll, STEP);
	endproperty
	a_gate_after_mpll: assert property (p_gate_after_mpll) else $error("gate early");
	property p_pd_needs_slumber;
		@(posedge clk) disable iff (!reset_n)
		start && !in_slumber && !release_req && step == slpc_pkg::PD_ON
		|=> refused && !pd.rx;
	endproperty
	a_pd_needs_slumber: assert property (p_pd_needs_slumber) else $error("pd without slumber");
endmodule : slpc_phy_pd
`default_nettype wire

// ==== hdl/slpc_top.sv ====
// Link power control, completion coalescing and PHY power-down top
`timescale 1ns/1ps
`default_nettype none
`include "slpc_regs.svh"
module slpc_top (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// AXI4-Lite register bus
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Link layer
	input wire slpc_pkg::slpc_rx_s rx,
	input wire logic tx_data_rdy,
	output slpc_pkg::slpc_prim_e tx_prim,
	output logic rx_fis_accept,
	output logic phy_partial,
	output logic phy_slumber,
	// Command completions and PRD progress
	input wire logic ccc_done,
	input wire logic [4:0] ccc_num,
	input wire logic prd_load,
	input wire logic [21:0] prd_len,
	input wire logic xfer_valid,
	input wire logic [12:0] xfer_bytes,
	// DMA write response
	input wire logic wr_ack,
	output logic dma_wrresp,
	// PHY power-down
	output slpc_pkg::slpc_phypd_s phy_pd,
	// Interrupt
	output logic irq
);
	localparam int TMO = `SLPC_PM_TMO_CYC;
	typedef struct packed {
		slpc_pkg::slpc_link_e link;
		slpc_pkg::slpc_pm_e pm;
		slpc_pkg::slpc_pm_e req_mode;
		logic sw_req;
		logic [7:0] tmo;
		slpc_pkg::slpc_prim_e prim;
		logic phy_p;
		logic phy_s;
		logic srst;
		logic fis_acc;
		logic pm_en;
		logic susp;
		logic pd_start;
		logic ccc_en;
		logic [7:0] ccc_thr;
		logic [7:0] ccnt;
		logic [21:0] rem;
		logic armed;
		logic wr_prev;
		logic wrresp;
		logic [`SLPC_NIRQ-1:0] isr;
		logic [`SLPC_NIRQ-1:0] imr;
		logic irq;
	} slpc_top_s;
	slpc_top_s s_q, s_d;

	slpc_pkg::slpc_wr_s wr;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	slpc_pkg::slpc_pd_e pd_step;
	logic pd_done;
	logic pd_refused;
	logic [8:0] ccc_sum;
	logic ccc_fold;
	logic dps_fire;

	// ----------------------------------------------------------------
	// Bus slave and power-down sequencer
	// ----------------------------------------------------------------
	slpc_axil u_axil (
		.clk(clk),
		.reset_n(reset_n),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.awaddr(s_axi_awaddr),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.bresp(s_axi_bresp),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.araddr(s_axi_araddr),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.wr(wr),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	slpc_phy_pd u_pd (
		.clk(clk),
		.reset_n(reset_n),
		.start(s_q.pd_start),
		.release_req(!s_q.susp),
		.in_slumber(s_q.phy_s),
		.pd(phy_pd),
		.step(pd_step),
		.done(pd_done),
		.refused(pd_refused)
	);

	// Completions in the clearing cycle are absorbed, never carried over
	assign ccc_sum = {1'b0, s_q.ccnt} + {4'h0, ccc_num};
	assign ccc_fold = s_q.ccc_en && ccc_done && (s_q.ccc_thr != 8'h00) &&
		(ccc_sum >= {1'b0, s_q.ccc_thr});
	assign dps_fire = s_q.armed && xfer_valid && !prd_load &&
		({9'h000, xfer_bytes} >= s_q.rem);

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_data = 32'h0000_0000;
		case (rd_addr)
			`SLPC_A_CTRL: begin
				rd_data[`SLPC_C_PMEN] = s_q.pm_en;
				rd_data[`SLPC_C_SUSP] = s_q.susp;
			end
			`SLPC_A_STAT: begin
				rd_data[2:0] = s_q.link;
				rd_data[`SLPC_ST_PM_LSB +: 2] = s_q.pm;
				rd_data[`SLPC_ST_PD_LSB +: 3] = pd_step;
			end
			`SLPC_A_ISR: rd_data[`SLPC_NIRQ-1:0] = s_q.isr;
			`SLPC_A_IMR: rd_data[`SLPC_NIRQ-1:0] = s_q.imr;
			`SLPC_A_CCC: begin
				rd_data[`SLPC_CCC_EN] = s_q.ccc_en;
				rd_data[`SLPC_CCC_THR_LSB +: 8] = s_q.ccc_thr;
			end
			`SLPC_A_CCNT: rd_data[7:0] = s_q.ccnt;
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0] cv;
		logic [`SLPC_NIRQ-1:0] ev;
		logic [`SLPC_NIRQ-1:0] w1c;
		logic sw_wake;
		logic ack;
		logic nak;
		cv = 32'h0000_0000;
		ev = '0;
		w1c = '0;
		sw_wake = 1'b0;
		ack = 1'b0;
		nak = 1'b0;
		s_d = s_q;
		s_d.srst = 1'b0;
		s_d.pd_start = 1'b0;
		if (wr.en && wr.addr == `SLPC_A_CTRL) begin
			sw_wake = wr.data[`SLPC_C_WAKE] && wr.strb[0];
		end

		// Link state machine; a soft reset always lands in idle
		if (s_q.srst) begin
			s_d.link = slpc_pkg::L_IDLE;
			s_d.pm = slpc_pkg::PM_NONE;
		end else begin
			case (s_q.link)
				slpc_pkg::L_IDLE: begin
					if (tx_data_rdy) begin
						s_d.link = slpc_pkg::L_TX;
					end else if (rx.xrdy) begin
						s_d.link = slpc_pkg::L_RX;
					end else if (rx.pmreq_p || rx.pmreq_s) begin
						if (s_q.pm_en) begin
							ack = 1'b1;
							s_d.link = slpc_pkg::L_PM;
							s_d.sw_req = 1'b0;
							// Drive Partial beats a pending Slumber
							s_d.pm = rx.pmreq_p ? slpc_pkg::PM_PARTIAL :
								slpc_pkg::PM_SLUMBER;
							ev[`SLPC_I_PMDONE] = 1'b1;
						end else begin
							nak = 1'b1;
						end
					end else if (s_q.sw_req) begin
						s_d.sw_req = 1'b0;
						s_d.tmo = 8'h00;
						if (s_q.pm_en) begin
							s_d.link = slpc_pkg::L_PMREQ;
						end
					end
				end
				slpc_pkg::L_TX: begin
					if (!tx_data_rdy) begin
						s_d.link = slpc_pkg::L_IDLE;
					end
				end
				slpc_pkg::L_RX: begin
					if (!rx.xrdy) begin
						s_d.link = slpc_pkg::L_IDLE;
					end
				end
				slpc_pkg::L_PMREQ: begin
					s_d.tmo = s_q.tmo + 8'h01;
					if (rx.pmack) begin
						s_d.link = slpc_pkg::L_PM;
						s_d.pm = s_q.req_mode;
						ev[`SLPC_I_PMDONE] = 1'b1;
					end else if (rx.xrdy) begin
						s_d.link = slpc_pkg::L_RX;
					end else if (rx.pmnak || s_q.tmo == 8'(TMO - 1)) begin
						s_d.link = slpc_pkg::L_IDLE;
					end
				end
				slpc_pkg::L_PM: begin
					if (rx.wake || sw_wake || tx_data_rdy) begin
						s_d.link = slpc_pkg::L_IDLE;
						s_d.pm = slpc_pkg::PM_NONE;
					end
				end
				default: s_d.link = slpc_pkg::L_IDLE;
			endcase
		end
		case (s_d.link)
			slpc_pkg::L_TX: s_d.prim = slpc_pkg::PR_XRDY;
			slpc_pkg::L_RX: s_d.prim = slpc_pkg::PR_RRDY;
			slpc_pkg::L_PMREQ: s_d.prim =
				(s_d.req_mode == slpc_pkg::PM_PARTIAL) ?
				slpc_pkg::PR_PMREQ_P : slpc_pkg::PR_PMREQ_S;
			default: s_d.prim = slpc_pkg::PR_SYNC;
		endcase
		if (ack) begin
			s_d.prim = slpc_pkg::PR_PMACK;
		end else if (nak) begin
			s_d.prim = slpc_pkg::PR_PMNAK;
		end
		// One mode field drives both requests, so they exclude each other
		s_d.phy_p = (s_d.link == slpc_pkg::L_PM) &&
			(s_d.pm == slpc_pkg::PM_PARTIAL);
		s_d.phy_s = (s_d.link == slpc_pkg::L_PM) &&
			(s_d.pm == slpc_pkg::PM_SLUMBER);
		// Data of a FIS that meets the soft reset is dropped
		s_d.fis_acc = rx.dvalid && !s_q.srst && !s_d.srst;

		// Register writes
		if (wr.en) begin
			case (wr.addr)
				`SLPC_A_CTRL: begin
					cv = slpc_pkg::slpc_wmask(32'h0000_0000, wr.data, wr.strb);
					cv[`SLPC_C_PMEN] = wr.strb[0] ? wr.data[`SLPC_C_PMEN] : s_q.pm_en;
					cv[`SLPC_C_SUSP] = wr.strb[0] ? wr.data[`SLPC_C_SUSP] : s_q.susp;
					s_d.pm_en = cv[`SLPC_C_PMEN];
					s_d.susp = cv[`SLPC_C_SUSP];
					s_d.pd_start = cv[`SLPC_C_SUSP] && !s_q.susp;
					s_d.srst = cv[`SLPC_C_SRST];
					if (cv[`SLPC_C_SLREQ] || cv[`SLPC_C_PAREQ]) begin
						s_d.sw_req = 1'b1;
						s_d.req_mode = cv[`SLPC_C_PAREQ] ?
							slpc_pkg::PM_PARTIAL : slpc_pkg::PM_SLUMBER;
					end
				end
				`SLPC_A_ISR: w1c = wr.data[`SLPC_NIRQ-1:0] & {`SLPC_NIRQ{wr.strb[0]}};
				`SLPC_A_IMR: begin
					if (wr.strb[0]) begin
						s_d.imr = wr.data[`SLPC_NIRQ-1:0];
					end
				end
				`SLPC_A_CCC: begin
					cv = slpc_pkg::slpc_wmask({16'h0000, s_q.ccc_thr,
						7'h00, s_q.ccc_en}, wr.data, wr.strb);
					s_d.ccc_en = cv[`SLPC_CCC_EN];
					s_d.ccc_thr = cv[`SLPC_CCC_THR_LSB +: 8];
				end
				default: begin
				end
			endcase
		end

		// Completion coalescing
		if (!s_q.ccc_en) begin
			s_d.ccnt = 8'h00;
		end else if (ccc_fold) begin
			s_d.ccnt = 8'h00;
			ev[`SLPC_I_CCC] = 1'b1;
		end else if (ccc_done) begin
			s_d.ccnt = ccc_sum[7:0];
		end

		// PRD progress: done only when its byte count runs out
		if (prd_load) begin
			s_d.rem = prd_len;
			s_d.armed = 1'b1;
		end else if (dps_fire) begin
			s_d.rem = 22'h000000;
			s_d.armed = 1'b0;
			ev[`SLPC_I_DPS] = 1'b1;
		end else if (s_q.armed && xfer_valid) begin
			s_d.rem = s_q.rem - {9'h000, xfer_bytes};
		end

		// A stretched acknowledge still yields a single response
		s_d.wr_prev = wr_ack;
		s_d.wrresp = wr_ack && !s_q.wr_prev;

		ev[`SLPC_I_PDDONE] = pd_done;
		ev[`SLPC_I_PDREF] = pd_refused;
		s_d.isr = (s_q.isr & ~w1c) | ev;
		s_d.irq = |(s_d.isr & s_d.imr);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
			s_q.imr <= `SLPC_IMR_RST;
			s_q.ccc_thr <= `SLPC_THR_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign tx_prim = s_q.prim;
	assign rx_fis_accept = s_q.fis_acc;
	assign phy_partial = s_q.phy_p;
	assign phy_slumber = s_q.phy_s;
	assign dma_wrresp = s_q.wrresp;
	assign irq = s_q.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_idle_ok;
		s_q.link == slpc_pkg::L_IDLE && !s_q.srst;
	endsequence
	sequence s_tx_collide;
		s_idle_ok ##0 tx_data_rdy && (rx.pmreq_p || rx.pmreq_s);
	endsequence
	property p_tx_wins;
		s_tx_collide |=> tx_prim == slpc_pkg::PR_XRDY && !phy_slumber && !phy_partial;
	endproperty
	a_tx_wins: assert property (p_tx_wins) else $error("pm request not ignored");
	property p_one_mode;
		!(phy_partial && phy_slumber);
	endproperty
	a_one_mode: assert property (p_one_mode) else $error("both pm requests");
	property p_partial_only;
		s_q.link == slpc_pkg::L_PMREQ && !s_q.srst && rx.pmack &&
		s_q.req_mode == slpc_pkg::PM_PARTIAL |=> phy_partial && !phy_slumber;
	endproperty
	a_partial_only: assert property (p_partial_only) else $error("wrong pm mode");
	property p_ccc_fold;
		ccc_fold |=> s_q.ccnt == 8'h00 && s_q.isr[`SLPC_I_CCC];
	endproperty
	a_ccc_fold: assert property (p_ccc_fold) else $error("ccc count not cleared");
	property p_dps_cause;
		$rose(s_q.isr[`SLPC_I_DPS]) |-> $past(dps_fire);
	endproperty
	a_dps_cause: assert property (p_dps_cause) else $error("early prd done");
	property p_wrresp_one;
		dma_wrresp |=> !dma_wrresp;
	endproperty
	a_wrresp_one: assert property (p_wrresp_one) else $error("long wr response");
	sequence s_srst_hit;
		s_q.srst;
	endsequence
	property p_srst_idle;
		s_srst_hit |=> s_q.link == slpc_pkg::L_IDLE && !phy_partial &&
			!phy_slumber && !rx_fis_accept;
	endproperty
	a_srst_idle: assert property (p_srst_idle) else $error("soft reset not idle");
	property p_rrdy;
		s_idle_ok ##0 !tx_data_rdy && rx.xrdy |=> tx_prim == slpc_pkg::PR_RRDY;
	endproperty
	a_rrdy: assert property (p_rrdy) else $error("no r_rdy answer");
endmodule : slpc_top
`default_nettype wire

// ==== test/slpc_drive_model.sv ====
// Drive-side model: power requests, acknowledges and X_RDY
`timescale 1ns/1ps
`default_nettype none
module slpc_drive_model (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Bench commands
	input wire logic cmd_p,
	input wire logic cmd_s,
	input wire logic cmd_x,
	// Link
	input wire slpc_pkg::slpc_prim_e tx_prim,
	output slpc_pkg::slpc_rx_s rx
);
	logic seen_q;
	logic host_req;
	logic answered;
	assign host_req = tx_prim == slpc_pkg::PR_PMREQ_P ||
		tx_prim == slpc_pkg::PR_PMREQ_S;
	assign answered = tx_prim == slpc_pkg::PR_XRDY ||
		tx_prim == slpc_pkg::PR_PMACK || tx_prim == slpc_pkg::PR_PMNAK;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx <= '0;
			seen_q <= 1'b0;
		end else begin
			// Request stands until answered; an X_RDY makes us give it up
			rx.pmreq_p <= (cmd_p || rx.pmreq_p) && !answered;
			rx.pmreq_s <= (cmd_s || rx.pmreq_s) && !answered;
			rx.xrdy <= cmd_x;
			rx.dvalid <= cmd_x;
			rx.wake <= 1'b0;
			rx.pmnak <= 1'b0;
			// Accept each host request once, not every cycle it stands
			rx.pmack <= host_req && !seen_q;
			seen_q <= host_req;
		end
	end
endmodule : slpc_drive_model
`default_nettype wire

// ==== test/sata_ahci_link_power_control_tb.sv ====
// Self-checking bench for the link power control block
`timescale 1ns/1ps
`default_nettype none
`include "slpc_regs.svh"
module sata_ahci_link_power_control_tb;
	logic clk, reset_n, awv, wv, bry, arv, rry, txr, cd, pl, xv, wa;
	logic cp, cs, cx;
	logic [7:0] awa, ara, thr;
	logic [31:0] wd, v;
	logic [3:0] ws;
	logic [4:0] cn;
	logic [21:0] plen;
	logic [12:0] xb;
	logic [1:0] r2;
	wire logic awr, wr, bv, arr, rv, fa, pp, ps, dw, irq;
	wire logic [1:0] br, rr;
	wire logic [31:0] rdt;
	slpc_pkg::slpc_rx_s rx;
	slpc_pkg::slpc_prim_e tp;
	slpc_pkg::slpc_phypd_s pd;
	int errors, checks_done, n, sum, len;
	slpc_top DUT (.clk(clk), .reset_n(reset_n), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdt),
		.s_axi_rresp(rr), .rx(rx), .tx_data_rdy(txr), .tx_prim(tp),
		.rx_fis_accept(fa), .phy_partial(pp), .phy_slumber(ps),
		.ccc_done(cd), .ccc_num(cn), .prd_load(pl), .prd_len(plen),
		.xfer_valid(xv), .xfer_bytes(xb), .wr_ack(wa), .dma_wrresp(dw),
		.phy_pd(pd), .irq(irq));
	slpc_drive_model u_drv (.clk(clk), .reset_n(reset_n), .cmd_p(cp),
		.cmd_s(cs), .cmd_x(cx), .tx_prim(tp), .rx(rx));
	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic chk(input string s, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask : cyc
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		bry <= 1'b1;
		forever begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
			if (bv) break;
		end
		chk("bresp", 32'h0, br);
		bry <= 1'b0;
	endtask : axw
	task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rry <= 1'b1;
		forever begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
			if (rv) break;
		end
		v = rdt;
		r2 = rr;
		rry <= 1'b0;
		chk("register", e, v & m);
	endtask : rc
	task automatic pulse_req(input logic part);
		@(posedge clk);
		if (part) cp <= 1'b1;
		else cs <= 1'b1;
		@(posedge clk);
		cp <= 1'b0;
		cs <= 1'b0;
	endtask : pulse_req
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict
	// Power mode exclusivity and power-down order, every cycle
	always @(posedge clk) begin
		if (reset_n) begin
			chk("both modes", 0, pp & ps);
			chk("pd order", 0, (pd.rx ^ pd.rx_pll) | (pd.tx & !pd.rx) |
				(pd.mpll & !pd.tx) | (pd.main_pll_clock_gate & !pd.mpll) |
				(pd.refclk_stop_ok & !pd.main_pll_clock_gate));
		end
	end
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#2000000;
		errors++;
		print_verdict();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{awv, wv, bry, arv, rry, txr, cd, pl, xv, wa, cp, cs, cx} = '0;
		{awa, ara, wd, cn, plen, xb} = '0;
		ws = 4'hf;
		errors = 0;
		checks_done = 0;
		reset_n = 1'b0;
		void'($urandom(18689));
		cyc(8);
		reset_n <= 1'b1;
		rc(`SLPC_A_IMR, 32'h1f, 32'h0);
		rc(8'h1c, 32'hffff_ffff, 32'h0);
		chk("rresp", 32'h2, r2);
		$display("test reset done");
		axw(`SLPC_A_CTRL, 32'h1);
		pulse_req(1'b0);
		txr <= 1'b1;
		cyc(2);
		chk("tx prim", slpc_pkg::PR_XRDY, tp);
		txr <= 1'b0;
		cyc(20);
		chk("slumber", 0, ps);
		$display("test collision done");
		axw(`SLPC_A_CTRL, 32'h5);
		cyc(4);
		chk("sw partial", 1, pp);
		chk("sw partial", 0, ps);
		axw(`SLPC_A_CTRL, 32'h21);
		pulse_req(1'b1);
		cyc(2);
		chk("partial", 1, pp);
		axw(`SLPC_A_IMR, 32'h4);
		cyc(2);
		chk("irq", 1, irq);
		axw(`SLPC_A_ISR, 32'h4);
		cyc(2);
		chk("irq", 0, irq);
		axw(`SLPC_A_CTRL, 32'h21);
		// Drive Partial and software Slumber meet in one idle cycle
		fork
			axw(`SLPC_A_CTRL, 32'h3);
			begin
				cyc(2);
				pulse_req(1'b1);
			end
		join
		cyc(5);
		chk("one mode", 1, pp | ps);
		chk("partial kept", 1, pp);
		axw(`SLPC_A_CTRL, 32'h21);
		$display("test power modes done");
		thr = 8'(4 + $urandom % 8);
		axw(`SLPC_A_CCC, {16'h0, thr, 8'h1});
		sum = 0;
		while (sum < thr) begin
			@(posedge clk);
			n = 1 + $urandom % 3;
			cd <= 1'b1;
			cn <= 5'(n);
			sum += n;
			@(posedge clk);
			cd <= 1'b0;
		end
		rc(`SLPC_A_CCNT, 32'hff, 32'h0);
		rc(`SLPC_A_ISR, 32'h1, 32'h1);
		axw(`SLPC_A_ISR, 32'h1);
		rc(`SLPC_A_ISR, 32'h1, 32'h0);
		$display("test coalescing done");
		len = 1024 + $urandom % 2048;
		@(posedge clk);
		pl <= 1'b1;
		plen <= 22'(len);
		@(posedge clk);
		pl <= 1'b0;
		xv <= 1'b1;
		xb <= 13'h200;
		@(posedge clk);
		xv <= 1'b0;
		rc(`SLPC_A_ISR, 32'h2, 32'h0);
		@(posedge clk);
		xv <= 1'b1;
		xb <= 13'(len - 512);
		@(posedge clk);
		xv <= 1'b0;
		rc(`SLPC_A_ISR, 32'h2, 32'h2);
		$display("test prd done");
		@(posedge clk);
		wa <= 1'b1;
		n = 0;
		repeat (6) begin
			@(posedge clk);
			n += dw;
		end
		wa <= 1'b0;
		chk("wrresp cycles", 1, n);
		$display("test write response done");
		axw(`SLPC_A_CTRL, 32'h8);
		pulse_req(1'b0);
		cyc(3);
		rc(`SLPC_A_STAT, 32'h7, 32'h0);
		@(posedge clk);
		cx <= 1'b1;
		// Soft reset lands while the drive is sending
		axw(`SLPC_A_CTRL, 32'h8);
		cyc(3);
		chk("tx prim", slpc_pkg::PR_RRDY, tp);
		chk("fis accept", 1, fa);
		cx <= 1'b0;
		$display("test soft reset done");
		axw(`SLPC_A_CTRL, 32'h11);
		cyc(3);
		rc(`SLPC_A_ISR, 32'h18, 32'h10);
		chk("pd", 0, 32'(pd));
		axw(`SLPC_A_CTRL, 32'h3);
		n = 0;
		while (!ps && n < 300) begin
			@(posedge clk);
			n++;
		end
		chk("slumber", 1, ps);
		axw(`SLPC_A_CTRL, 32'h11);
		n = 0;
		while (!pd.refclk_stop_ok && n < 300) begin
			@(posedge clk);
			n++;
		end
		chk("pd", 32'h3f, 32'(pd));
		chk("pd span", 4 * `SLPC_PD_STEP_CYC + 2, n);
		rc(`SLPC_A_ISR, 32'h8, 32'h8);
		$display("test power down done");
		print_verdict();
	end
endmodule : sata_ahci_link_power_control_tb
`default_nettype wire
